// ===== core/pdfl_pkg.sv
// constants and types shared by the pump drive and fault latch block
package pdfl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned WD_TIMEOUT_MS = 100;
  localparam int unsigned PULLIN_MS     = 500;
  localparam int unsigned OC_QUAL_MS    = 3000;
  localparam int unsigned SPEED_WIN_MS  = 10;

  // ---------------------------------------------------------------
  // channel counts and roles
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PUMPS  = 4;
  localparam int unsigned NUM_CLAMPS = 8;
  localparam int unsigned AC_CH      = 0;
  localparam int unsigned BLOOD_CH   = 1;
  localparam int unsigned CELL_CH    = 2;
  localparam int unsigned SPEED_W    = 8;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_SPEED0 = 8'h04;
  localparam logic [7:0]  ADDR_SPEED3 = 8'h10;
  localparam logic [7:0]  ADDR_CLAMP  = 8'h14;
  localparam logic [7:0]  ADDR_STROBE = 8'h18;
  localparam logic [7:0]  ADDR_STATUS = 8'h1C;

  localparam int unsigned CTRL_DIR_LSB   = 0;
  localparam int unsigned CTRL_TEST_BIT  = 4;
  localparam int unsigned CTRL_CLR_BIT   = 8;
  localparam int unsigned STAT_LATCH_BIT = 6;
  localparam int unsigned STAT_BDIR_BIT  = 7;
  localparam int unsigned STAT_PULL_LSB  = 8;

  // fault source bit positions in the latch
  localparam int unsigned FS_STOP = 0;
  localparam int unsigned FS_AIR  = 1;
  localparam int unsigned FS_WD   = 2;
  localparam int unsigned FS_OSPD = 3;
  localparam int unsigned FS_OCUR = 4;
  localparam int unsigned FS_TEST = 5;
  localparam int unsigned FS_W    = 6;

  typedef logic [2:0] pdfl_hall_t;

endpackage

// ===== core/pdfl_chan_if.sv
// signals between the control core and one pump motor channel
`timescale 1ns/1ps
`default_nettype none
interface pdfl_chan_if;
  import pdfl_pkg::*;
  logic               dir;
  logic [SPEED_W-1:0] speed_cmd;
  logic               force_tach;
  pdfl_hall_t         hall;
  logic               tach;
  logic [2:0]         phase_hi;
  logic [2:0]         phase_lo;
  modport core (output dir, speed_cmd, force_tach, hall, input tach, phase_hi, phase_lo);
  modport chan (input dir, speed_cmd, force_tach, hall, output tach, phase_hi, phase_lo);
endinterface
`default_nettype wire

// ===== core/pdfl_motor_chan.sv
// one brushless pump channel: commutation lookup, tach pulses, speed loop pwm
`timescale 1ns/1ps
`default_nettype none
module pdfl_motor_chan
  import pdfl_pkg::*;
#(
  parameter int unsigned SPEED_WIN_CYC = SPEED_WIN_MS * CLK_KHZ
) (
  input wire logic  pclk,
  input wire logic  presetn,
  pdfl_chan_if.chan ch
);

  // ---------------------------------------------------------------
  // commutation lookup
  // ---------------------------------------------------------------
  // address is {dir, hall}; result is {high side[2:0], low side[2:0]}
  function automatic logic [5:0] comm_lookup(input logic [3:0] addr);
    logic [5:0] fwd;
    fwd = 6'h00;
    unique case (addr[2:0])
      3'h5:    fwd = 6'h0A;
      3'h4:    fwd = 6'h0C;
      3'h6:    fwd = 6'h14;
      3'h2:    fwd = 6'h11;
      3'h3:    fwd = 6'h21;
      3'h1:    fwd = 6'h22;
      default: fwd = 6'h00;
    endcase
    // reverse swaps which phase is driven and which returns
    return addr[3] ? {fwd[2:0], fwd[5:3]} : fwd;
  endfunction

  logic [5:0]         drive;
  logic               sq_wave;
  logic               sq_reg;
  logic               tach_reg;
  logic [7:0]         pwm_cnt_reg;
  logic [7:0]         duty_reg;
  logic [SPEED_W-1:0] pulse_cnt_reg;
  logic [31:0]        win_cnt_reg;
  logic               pwm_on;

  assign drive   = comm_lookup({ch.dir, ch.hall});
  assign sq_wave = ^ch.hall;
  assign pwm_on  = pwm_cnt_reg < duty_reg;

  // ---------------------------------------------------------------
  // bridge drive: one phase to return, one floating, one pwm-gated
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch.phase_hi <= 3'h0;
      ch.phase_lo <= 3'h0;
    end else begin
      ch.phase_hi <= drive[5:3] & {3{pwm_on}};
      ch.phase_lo <= drive[2:0];
    end
  end

  // ---------------------------------------------------------------
  // tach: one pulse per square wave edge gives twelve per revolution
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_reg   <= 1'b0;
      tach_reg <= 1'b0;
    end else begin
      sq_reg   <= sq_wave;
      tach_reg <= ch.force_tach | (sq_wave != sq_reg);
    end
  end
  assign ch.tach = tach_reg;

  // ---------------------------------------------------------------
  // speed loop: pulses per window against the commanded level
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_reg   <= 8'h00;
      win_cnt_reg   <= 32'h0;
      pulse_cnt_reg <= '0;
      duty_reg      <= 8'h00;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      if (win_cnt_reg >= SPEED_WIN_CYC - 1) begin
        win_cnt_reg   <= 32'h0;
        pulse_cnt_reg <= '0;
        if (pulse_cnt_reg < ch.speed_cmd && duty_reg != 8'hFF) begin
          duty_reg <= duty_reg + 8'h01;
        end else if (pulse_cnt_reg > ch.speed_cmd && duty_reg != 8'h00) begin
          duty_reg <= duty_reg - 8'h01;
        end
      end else begin
        win_cnt_reg <= win_cnt_reg + 32'h1;
        if (tach_reg && !ch.force_tach && pulse_cnt_reg != '1) begin
          pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/pdfl_top.sv
// pump drive control with fault latch, watchdog, clamp timing and apb registers
//
// Function
// - any abnormal input latches fault, drops relay
// - watchdog fault forces all tach lines high
// - latch sources readable by processor for selftest
// - missing strobes time out, raise dead flag
// - watchdog timeout pulses non-maskable interrupt
// - lookup addressed by hall code plus direction
// - two patterns, direction bit reverses motor
// - one phase return, one floating, one pwm
// - six-cycle square wave yields twelve tach pulses
// - current above reference raises overcurrent fault
// - voltage above reference raises overspeed fault
// - speed command sets level, pwm tracks it
// - ac/blood power only without fault; cell always
// - blood pump overcurrent qualified for three seconds
// - blood pump direction readable from hardware
// - four pump channels, eight clamp channels
// - clamp pull-in half second, then hold
`timescale 1ns/1ps
`default_nettype none
module pdfl_top
  import pdfl_pkg::*;
#(
  parameter int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_KHZ,
  parameter int unsigned PULLIN_CYC     = PULLIN_MS * CLK_KHZ,
  parameter int unsigned OC_QUAL_CYC    = OC_QUAL_MS * CLK_KHZ,
  parameter int unsigned SPEED_WIN_CYC  = SPEED_WIN_MS * CLK_KHZ
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    stop_pressed,
  input  wire logic                    air_detected,
  input  wire logic [NUM_PUMPS-1:0]    overcurrent_cmp,
  input  wire logic [NUM_PUMPS-1:0]    overspeed_cmp,
  input  wire logic [3*NUM_PUMPS-1:0]  hall_code,
  output var  logic                    pump_power_relay,
  output var  logic [NUM_PUMPS-1:0]    pump_power_en,
  output logic [NUM_PUMPS-1:0]         pump_tach_pulses,
  output logic [3*NUM_PUMPS-1:0]       phase_high,
  output logic [3*NUM_PUMPS-1:0]       phase_low,
  output var  logic                    dead_processor_flag,
  output var  logic                    nmi_n,
  output var  logic [NUM_CLAMPS-1:0]   clamp_pullin,
  output var  logic [NUM_CLAMPS-1:0]   clamp_hold
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 2 + 2 * NUM_PUMPS + 3 * NUM_PUMPS;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] pin_reg;

  assign pin_raw = {hall_code, overspeed_cmp, overcurrent_cmp, air_detected, stop_pressed};

  // a change is accepted only once two late stages agree, rejecting one-cycle glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  logic                   stop_f;
  logic                   air_f;
  logic [NUM_PUMPS-1:0]   oc_f;
  logic [NUM_PUMPS-1:0]   os_f;
  logic [3*NUM_PUMPS-1:0] hall_f;

  assign stop_f = pin_reg[0];
  assign air_f  = pin_reg[1];
  assign oc_f   = pin_reg[2 +: NUM_PUMPS];
  assign os_f   = pin_reg[2 + NUM_PUMPS +: NUM_PUMPS];
  assign hall_f = pin_reg[2 + 2 * NUM_PUMPS +: 3 * NUM_PUMPS];

  // ---------------------------------------------------------------
  // apb slave: zero wait states, read data captured in setup
  // ---------------------------------------------------------------
  logic [NUM_PUMPS-1:0]         dir_reg;
  logic                         test_fault_reg;
  logic [SPEED_W-1:0]           speed_reg [NUM_PUMPS];
  logic [NUM_CLAMPS-1:0]        clamp_cmd_reg;
  logic [FS_W-1:0]              fault_src_reg;
  logic                         blood_dir_reg;
  logic                         wr_en;
  logic                         addr_hit;
  logic                         clr_pulse;
  logic                         strobe_pulse;
  logic [31:0]                  rd_mux;

  function automatic logic is_speed(input logic [ADDR_W-1:0] a);
    return a >= ADDR_SPEED0 && a <= ADDR_SPEED3 && a[1:0] == 2'b00;
  endfunction

  function automatic int unsigned speed_idx(input logic [ADDR_W-1:0] a);
    return int'(a - ADDR_SPEED0) >> 2;
  endfunction

  assign addr_hit     = paddr == ADDR_CTRL || is_speed(paddr) || paddr == ADDR_CLAMP ||
                        paddr == ADDR_STROBE || paddr == ADDR_STATUS;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~addr_hit;
  assign wr_en        = psel & penable & pwrite & addr_hit;
  assign clr_pulse    = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_CLR_BIT];
  assign strobe_pulse = wr_en && paddr == ADDR_STROBE;

  always_comb begin
    rd_mux = 32'h0;
    if (paddr == ADDR_CTRL) begin
      rd_mux[CTRL_DIR_LSB +: NUM_PUMPS] = dir_reg;
      rd_mux[CTRL_TEST_BIT]             = test_fault_reg;
    end else if (is_speed(paddr)) begin
      rd_mux[SPEED_W-1:0] = speed_reg[speed_idx(paddr)];
    end else if (paddr == ADDR_CLAMP) begin
      rd_mux[NUM_CLAMPS-1:0] = clamp_cmd_reg;
    end else if (paddr == ADDR_STATUS) begin
      rd_mux[FS_W-1:0]                      = fault_src_reg;
      rd_mux[STAT_LATCH_BIT]                = |fault_src_reg;
      rd_mux[STAT_BDIR_BIT]                 = blood_dir_reg;
      rd_mux[STAT_PULL_LSB +: NUM_CLAMPS]   = clamp_pullin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg        <= '0;
      test_fault_reg <= 1'b0;
      clamp_cmd_reg  <= '0;
      for (int i = 0; i < NUM_PUMPS; i++) begin
        speed_reg[i] <= '0;
      end
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        dir_reg        <= pwdata[CTRL_DIR_LSB +: NUM_PUMPS];
        test_fault_reg <= pwdata[CTRL_TEST_BIT];
      end else if (is_speed(paddr)) begin
        speed_reg[speed_idx(paddr)] <= pwdata[SPEED_W-1:0];
      end else if (paddr == ADDR_CLAMP) begin
        clamp_cmd_reg <= pwdata[NUM_CLAMPS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  logic [31:0] wd_cnt_reg;
  logic        wd_expire;

  assign wd_expire = !strobe_pulse && wd_cnt_reg == WD_TIMEOUT_CYC - 1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_reg <= 32'h0;
      nmi_n      <= 1'b1;
    end else begin
      nmi_n <= ~wd_expire;
      if (strobe_pulse) begin
        wd_cnt_reg <= 32'h0;
      end else if (wd_cnt_reg < WD_TIMEOUT_CYC) begin
        wd_cnt_reg <= wd_cnt_reg + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // overcurrent qualification and fault latch
  // ---------------------------------------------------------------
  logic [31:0]     oc_qual_cnt_reg;
  logic            oc_any;
  logic [FS_W-1:0] fault_set;

  // reversal used as a fast stop draws a long surge on the blood pump
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_qual_cnt_reg <= 32'h0;
    end else if (!oc_f[BLOOD_CH]) begin
      oc_qual_cnt_reg <= 32'h0;
    end else if (oc_qual_cnt_reg < OC_QUAL_CYC) begin
      oc_qual_cnt_reg <= oc_qual_cnt_reg + 32'h1;
    end
  end

  always_comb begin
    oc_any = 1'b0;
    for (int i = 0; i < NUM_PUMPS; i++) begin
      if (i == BLOOD_CH) begin
        oc_any = oc_any | (oc_qual_cnt_reg >= OC_QUAL_CYC);
      end else begin
        oc_any = oc_any | oc_f[i];
      end
    end
  end

  always_comb begin
    fault_set          = '0;
    fault_set[FS_STOP] = stop_f;
    fault_set[FS_AIR]  = air_f;
    fault_set[FS_WD]   = wd_expire;
    fault_set[FS_OSPD] = |os_f;
    fault_set[FS_OCUR] = oc_any;
    fault_set[FS_TEST] = test_fault_reg;
  end

  // a source present in the clear cycle stays latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_src_reg <= '0;
    end else begin
      fault_src_reg <= (clr_pulse ? '0 : fault_src_reg) | fault_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_power_relay    <= 1'b0;
      pump_power_en       <= '0;
      dead_processor_flag <= 1'b0;
    end else begin
      pump_power_relay    <= ~|fault_src_reg;
      dead_processor_flag <= fault_src_reg[FS_WD];
      for (int i = 0; i < NUM_PUMPS; i++) begin
        pump_power_en[i] <= (i == CELL_CH) ? 1'b1 : ~|fault_src_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // pump channels
  // ---------------------------------------------------------------
  pdfl_chan_if chan_if [NUM_PUMPS] ();

  for (genvar g = 0; g < NUM_PUMPS; g++) begin : g_pump
    assign chan_if[g].dir        = dir_reg[g];
    assign chan_if[g].speed_cmd  = speed_reg[g];
    assign chan_if[g].force_tach = fault_src_reg[FS_WD];
    assign chan_if[g].hall       = hall_f[3*g +: 3];
    assign pump_tach_pulses[g]   = chan_if[g].tach;
    assign phase_high[3*g +: 3]  = chan_if[g].phase_hi;
    assign phase_low[3*g +: 3]   = chan_if[g].phase_lo;

    pdfl_motor_chan #(
      .SPEED_WIN_CYC (SPEED_WIN_CYC)
    ) u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .ch      (chan_if[g])
    );
  end

  // ---------------------------------------------------------------
  // blood pump direction from hall sequence
  // ---------------------------------------------------------------
  function automatic pdfl_hall_t hall_fwd_next(input pdfl_hall_t h);
    unique case (h)
      3'h5:    return 3'h4;
      3'h4:    return 3'h6;
      3'h6:    return 3'h2;
      3'h2:    return 3'h3;
      3'h3:    return 3'h1;
      3'h1:    return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  pdfl_hall_t bhall_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bhall_reg     <= 3'h0;
      blood_dir_reg <= 1'b0;
    end else begin
      bhall_reg <= hall_f[3*BLOOD_CH +: 3];
      if (hall_f[3*BLOOD_CH +: 3] != bhall_reg && hall_fwd_next(bhall_reg) != 3'h0) begin
        blood_dir_reg <= hall_fwd_next(bhall_reg) != hall_f[3*BLOOD_CH +: 3];
      end
    end
  end

  // ---------------------------------------------------------------
  // clamp drivers
  // ---------------------------------------------------------------
  logic [31:0] pull_cnt_reg [NUM_CLAMPS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_pullin <= '0;
      clamp_hold   <= '0;
      for (int i = 0; i < NUM_CLAMPS; i++) begin
        pull_cnt_reg[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < NUM_CLAMPS; i++) begin
        if (!clamp_cmd_reg[i]) begin
          pull_cnt_reg[i] <= 32'h0;
          clamp_pullin[i] <= 1'b0;
          clamp_hold[i]   <= 1'b0;
        end else if (pull_cnt_reg[i] < PULLIN_CYC) begin
          pull_cnt_reg[i] <= pull_cnt_reg[i] + 32'h1;
          clamp_pullin[i] <= 1'b1;
          clamp_hold[i]   <= 1'b0;
        end else begin
          clamp_pullin[i] <= 1'b0;
          clamp_hold[i]   <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_fault_drops_relay;
    @(posedge pclk) disable iff (!presetn) $rose(stop_f) |-> ##2 !pump_power_relay;
  endproperty
  a_fault_drops_relay: assert property (p_fault_drops_relay) else $error("relay not dropped on stop");

  property p_latch_holds;
    @(posedge pclk) disable iff (!presetn) (|fault_src_reg && !clr_pulse) |=> |fault_src_reg;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("fault latch released");

  property p_wd_tach_high;
    @(posedge pclk) disable iff (!presetn) fault_src_reg[FS_WD] |=> &pump_tach_pulses;
  endproperty
  a_wd_tach_high: assert property (p_wd_tach_high) else $error("tach not forced high");

  property p_wd_nmi;
    @(posedge pclk) disable iff (!presetn) wd_expire |=> !nmi_n ##1 (nmi_n && dead_processor_flag);
  endproperty
  a_wd_nmi: assert property (p_wd_nmi) else $error("watchdog timeout not signalled");

  property p_cell_power;
    @(posedge pclk) disable iff (!presetn) $past(presetn) |-> pump_power_en[CELL_CH];
  endproperty
  a_cell_power: assert property (p_cell_power) else $error("cell pump unpowered");

  property p_ac_power;
    @(posedge pclk) disable iff (!presetn) pump_power_en[AC_CH] |-> $past(fault_src_reg) == '0;
  endproperty
  a_ac_power: assert property (p_ac_power) else $error("ac pump powered under fault");

  property p_oc_qual;
    @(posedge pclk) disable iff (!presetn)
      $rose(oc_f[BLOOD_CH]) |-> oc_qual_cnt_reg == 32'h0 ##1 (oc_qual_cnt_reg < OC_QUAL_CYC)[*2];
  endproperty
  a_oc_qual: assert property (p_oc_qual) else $error("blood overcurrent unqualified");

  property p_clamp_pullin;
    @(posedge pclk) disable iff (!presetn)
      $rose(clamp_cmd_reg[0]) |=> clamp_pullin[0] && !clamp_hold[0] ##1 clamp_pullin[0];
  endproperty
  a_clamp_pullin: assert property (p_clamp_pullin) else $error("clamp pull-in missing");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn) (psel && penable && !addr_hit) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_wd_timeout: cover property (@(posedge pclk) disable iff (!presetn) wd_expire);
  c_clamp_hold: cover property (@(posedge pclk) disable iff (!presetn) $rose(clamp_hold[0]));
  c_latch_clear: cover property (@(posedge pclk) disable iff (!presetn) clr_pulse && |fault_src_reg);

endmodule
`default_nettype wire

// ===== testbench/pdfl_host_model.sv
// host processor model: apb master and tach pulse counter
`timescale 1ns/1ps
`default_nettype none
module pdfl_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        tach,
  output var logic [15:0]  tach_count
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    tach_count = '0;
  end
  // speed is measured by counting tach pulses
  always @(posedge pclk) begin
    if (tach) tach_count <= tach_count + 16'h0001;
  end
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the pump drive and fault latch block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pdfl_pkg::*;
  logic pclk, presetn, stop_pressed, psel, penable, pwrite, pready, pslverr, relay, dead, nmi_n;
  logic [7:0]  paddr, pullin, hold;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  en, tach, ocur, ospd;
  logic [11:0] hall, ph_hi, ph_lo;
  logic        air;
  logic [15:0] tcount;
  logic        err;
  int          n_fail = 0, checked = 0, cyc = 0, nlow, nhigh;
  pdfl_top #(.WD_TIMEOUT_CYC(200), .PULLIN_CYC(50), .OC_QUAL_CYC(100), .SPEED_WIN_CYC(64)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_pressed(stop_pressed), .air_detected(air), .overcurrent_cmp(ocur),
    .overspeed_cmp(ospd), .hall_code(hall), .pump_power_relay(relay), .pump_power_en(en),
    .pump_tach_pulses(tach), .phase_high(ph_hi), .phase_low(ph_lo), .dead_processor_flag(dead),
    .nmi_n(nmi_n), .clamp_pullin(pullin), .clamp_hold(hold));
  pdfl_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tach(tach[0]), .tach_count(tcount));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // strobe restarts the watchdog at the start of each scenario; t_motor and t_watchdog outlast the timeout
  task automatic strobe();
    u_host.xfer(1'b1, ADDR_STROBE, 32'h1, q, err);
  endtask
  task automatic t_stop_latch();
    strobe();
    stop_pressed <= 1'b1;
    repeat (8) @(posedge pclk);
    stop_pressed <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(relay, 1'b0);
    chk(en, 4'h4);
    u_host.xfer(1'b0, ADDR_STATUS, 32'h0, q, err);
    chk(q, 32'h41);
    u_host.xfer(1'b1, ADDR_CTRL, 32'h100, q, err);
    repeat (3) @(posedge pclk);
    chk(relay, 1'b1);
    chk(en, 4'hF);
  endtask
  task automatic t_watchdog();
    strobe();
    nlow = 0;
    repeat (230) begin
      @(posedge pclk);
      if (nmi_n === 1'b0) nlow++;
    end
    chk(nlow, 1);
    chk(dead, 1'b1);
    chk(tach, 4'hF);
    chk(relay, 1'b0);
    strobe();
    u_host.xfer(1'b1, ADDR_CTRL, 32'h100, q, err);
    repeat (3) @(posedge pclk);
    chk(dead, 1'b0);
  endtask
  task automatic t_clamp();
    strobe();
    u_host.xfer(1'b1, ADDR_CLAMP, 32'h81, q, err);
    repeat (2) @(posedge pclk);
    chk({pullin, hold}, 16'h8100);
    repeat (55) @(posedge pclk);
    chk({pullin, hold}, 16'h0081);
    u_host.xfer(1'b1, ADDR_CLAMP, 32'h0, q, err);
    repeat (2) @(posedge pclk);
    chk({pullin, hold}, 16'h0000);
    u_host.xfer(1'b0, 8'h20, 32'h0, q, err);
    chk(err, 1'b1);
    chk(q, 32'h0);
  endtask
  task automatic t_faults();
    strobe();
    ocur <= 4'h2;
    repeat (60) @(posedge pclk);
    chk(relay, 1'b1);
    repeat (60) @(posedge pclk);
    chk(relay, 1'b0);
    ocur <= 4'h0;
    ospd <= 4'h8;
    repeat (6) @(posedge pclk);
    u_host.xfer(1'b0, ADDR_STATUS, 32'h0, q, err);
    chk(q, 32'h58);
    ospd <= 4'h0;
    strobe();
    u_host.xfer(1'b1, ADDR_CTRL, 32'h100, q, err);
    air <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(relay, 1'b0);
    air <= 1'b0;
    repeat (6) @(posedge pclk);
    u_host.xfer(1'b1, ADDR_CTRL, 32'h100, q, err);
    repeat (3) @(posedge pclk);
    chk(relay, 1'b1);
  endtask
  // the long pwm span lets the watchdog expire; t_watchdog starts from that state
  task automatic t_motor();
    strobe();
    chk(ph_lo[2:0], 3'h2);
    u_host.xfer(1'b1, ADDR_CTRL, 32'h1, q, err);
    repeat (2) @(posedge pclk);
    chk(ph_lo[2:0], 3'h4);
    nlow = tcount;
    hall <= 12'h25B;
    repeat (10) @(posedge pclk);
    chk(tcount - nlow, 32'h1);
    u_host.xfer(1'b0, ADDR_STATUS, 32'h0, q, err);
    chk(q[STAT_BDIR_BIT], 1'b1);
    u_host.xfer(1'b1, ADDR_SPEED0, 32'h10, q, err);
    nlow = 0;
    nhigh = 0;
    repeat (256) begin
      @(posedge pclk);
      if (ph_hi[2:0] !== 3'h0) nlow++;
    end
    repeat (256) begin
      @(posedge pclk);
      if (ph_hi[2:0] !== 3'h0) nhigh++;
    end
    chk(nhigh > nlow, 1'b1);
  endtask
  initial begin
    presetn = 1'b0;
    stop_pressed = 1'b0;
    air = 1'b0;
    ocur = 4'h0;
    ospd = 4'h0;
    hall = 12'h249;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(relay, 1'b1);
    t_stop_latch();
    t_clamp();
    t_faults();
    t_motor();
    t_watchdog();
    wrap_up();
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
